// ==== dv/dwps_watch_monitor.sv ====
// external monitor model: sticky record of watch lines seen
`timescale 1ns/10ps
module dwps_watch_monitor (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [21:0] watch_pulse_vec_i,
   output logic      [21:0] seen_o
);
   // sticky, since each line pulses one cycle only
   always @(posedge core_clk_i or negedge nrst_i)
      if (!nrst_i)
         seen_o <= 22'h0;
      else
         seen_o <= seen_o | watch_pulse_vec_i;
endmodule

// ==== dv/dwps_watch_props.sv ====
// port checker for the debug watchpoint block
`timescale 1ns/10ps
module dwps_watch_props (
   // clock, reset and bus
   input wire logic        core_clk_i,
   input wire logic        nrst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // event sources and lines
   input wire logic [7:0]  instr_addr_match_i,
   input wire logic [1:0]  dbg_counter_expire_i,
   input wire logic        ext_event_in_a_i,
   input wire logic        ext_event_in_b_i,
   input wire logic        irq_taken_event_i,
   input wire logic        irq_return_event_i,
   input wire logic        crit_irq_taken_event_i,
   input wire logic        crit_return_event_i,
   input wire logic        debug_enter_i,
   input wire logic        go_exit_i,
   input wire logic [21:0] watch_pulse_vec_o
);
   logic       sess_reg;
   logic [3:0] evout_reg;
   wire        wr_go = psel_i & penable_i & pwrite_i;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // shadow session and event-output writes, exit wins over entry
   always @(posedge core_clk_i or negedge nrst_i)
      if (!nrst_i) begin
         sess_reg  <= 1'b0;
         evout_reg <= 4'h0;
      end else begin
         sess_reg  <= go_exit_i ? 1'b0 : (debug_enter_i | sess_reg);
         evout_reg <= (wr_go && paddr_i == 8'h04) ? pwdata_i[3:0] : 4'h0;
      end
   ia_low_a: assert property (instr_addr_match_i[3:0] == 4'h0 |=>
      watch_pulse_vec_o[3:0] == 4'h0) else $error("compare line 0-3 stray");
   ia_high_a: assert property (instr_addr_match_i[7:4] == 4'h0 |=>
      {watch_pulse_vec_o[15:14], watch_pulse_vec_o[9:8]} == 4'h0)
      else $error("compare line 8,9,14,15 stray");
   cnt_line_a: assert property (dbg_counter_expire_i == 2'b00 |=>
      watch_pulse_vec_o[7:6] == 2'b00) else $error("counter line stray");
   ext_line_a: assert property (!ext_event_in_a_i && !ext_event_in_b_i
      |=> watch_pulse_vec_o[11:10] == 2'b00) else $error("ext line stray");
   irq_line_a: assert property ({crit_return_event_i,
      crit_irq_taken_event_i, irq_return_event_i, irq_taken_event_i} == 4'h0
      |=> watch_pulse_vec_o[19:16] == 4'h0) else $error("irq line stray");
   sess_block_a: assert property (sess_reg && !go_exit_i |=>
      (watch_pulse_vec_o & 22'h0fc3ff) == 22'h0) else $error("not blocked");
   evout_line_a: assert property ({watch_pulse_vec_o[21:20],
      watch_pulse_vec_o[13:12]} == $past(evout_reg)) else $error("evout bad");
   bus_ready_a: assert property (psel_i |-> pready_o) else $error("no ready");
   bus_err_a: assert property (psel_i && penable_i && paddr_i > 8'h14
      |-> pslverr_o) else $error("no slave error");
endmodule

// ==== dv/dwps_watchpoint_test.sv ====
// self-checking bench for the debug watchpoint block
`timescale 1ns/10ps
module dwps_watchpoint_test;
   logic core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, err;
   logic dbg_irq_enable_i, debug_enter_i, go_exit_i, pready_o, pslverr_o;
   logic ext_event_in_a_i, ext_event_in_b_i, irq_taken_event_i, irq_o;
   logic irq_return_event_i, crit_irq_taken_event_i, crit_return_event_i;
   logic [1:0]  data_addr_match_i, data_match_is_store_i, dbg_counter_expire_i;
   logic [7:0]  paddr_i, instr_addr_match_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [19:0] ev;
   logic [21:0] watch_pulse_vec_o, seen;
   int          errors, n_compared;
   // one packed event word feeds every source port
   assign {crit_return_event_i, crit_irq_taken_event_i, irq_return_event_i,
      irq_taken_event_i, ext_event_in_b_i, ext_event_in_a_i,
      dbg_counter_expire_i, data_match_is_store_i, data_addr_match_i,
      instr_addr_match_i} = ev;
   dwps_watchpoint dwps_watchpoint_i (.*);
   dwps_watch_monitor dwps_watch_monitor_i (.core_clk_i(core_clk_i),
      .nrst_i(nrst_i), .watch_pulse_vec_i(watch_pulse_vec_o), .seen_o(seen));
   function automatic logic [21:0] map(input logic [19:0] e);
      return {2'b00, e[19:16], e[7:6], 2'b00, e[15:14], e[5:4], e[13:12],
         e[9:8], e[3:0]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         errors++;
         $display("Error %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do @(posedge core_clk_i); while (pready_o !== 1'b1);
      {rd, err} = {prdata_o, pslverr_o};
      {psel_i, penable_i} <= 2'b00;
   endtask
   // one-cycle event, line expected next cycle then gone
   task automatic fire(input logic [19:0] e, input logic [21:0] x);
      @(posedge core_clk_i);
      ev <= e;
      @(posedge core_clk_i);
      ev <= 20'h0;
      #1 chk(watch_pulse_vec_o, x);
      @(posedge core_clk_i);
      #1 chk(watch_pulse_vec_o, 22'h0);
   endtask
   task automatic t_gating;
      apb(1'b0, 8'h00, 0);
      chk(rd, 0);
      fire(20'hfffff, 22'h0);
      chk(seen, 0);
      apb(1'b1, 8'h00, 2);
      dbg_irq_enable_i <= 1'b1;
      fire(20'hfffff, map(20'hfffff));
      apb(1'b1, 8'h00, 5);
      fire(20'h00f00, 22'h20);
      fire(20'h00300, 22'h30);
      apb(1'b1, 8'h00, 1);
      fire(20'h5a5a5, map(20'h5a5a5));
   endtask
   task automatic t_session;
      @(posedge core_clk_i);
      debug_enter_i <= 1'b1;
      @(posedge core_clk_i);
      debug_enter_i <= 1'b0;
      apb(1'b0, 8'h08, 0);
      chk(rd, 1);
      fire(20'hfffff, 22'h000c00);
      apb(1'b1, 8'h04, 32'hf);
      @(posedge core_clk_i);
      #1 chk(watch_pulse_vec_o, 22'h303000);
      go_exit_i <= 1'b1;
      @(posedge core_clk_i);
      go_exit_i <= 1'b0;
      fire(20'hfffff, map(20'hfffff));
      apb(1'b1, 8'h00, 0);
      apb(1'b1, 8'h04, 32'h5);
      @(posedge core_clk_i);
      #1 chk(watch_pulse_vec_o, 22'h101000);
   endtask
   task automatic t_irq;
      apb(1'b0, 8'h0c, 0);
      chk(rd, 7);
      apb(1'b1, 8'h10, 4);
      #1 chk(irq_o, 1);
      apb(1'b1, 8'h0c, 4);
      #1 chk(irq_o, 0);
      apb(1'b0, 8'h40, 0);
      chk({rd[30:0], err}, 1);
      chk(seen, 22'h3fffff);
   endtask
   task automatic close_out;
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   // run needs under a hundred cycles; cut off well beyond
   initial begin
      #20000;
      errors++;
      close_out();
   end
   initial begin
      {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, ev} = '0;
      {dbg_irq_enable_i, debug_enter_i, go_exit_i, errors, n_compared} = '0;
      repeat (5) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      #1 chk(watch_pulse_vec_o, 0);
      t_gating();
      t_session();
      t_irq();
      close_out();
   end
endmodule
bind dwps_watchpoint dwps_watch_props dwps_watch_props_i (.*);

// ==== rtl/dwps_watchpoint.v ====
// debug watchpoint signalling block with apb register slave
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "dwps_regs.vh"
module dwps_watchpoint (
   // clock and reset
   input  wire        core_clk_i,
   input  wire        nrst_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire        pready_o,
   output wire        pslverr_o,
   output reg  [31:0] prdata_o,
   // core debug event sources, one-cycle pulses, then the debug interrupt enable level
   input  wire [7:0]  instr_addr_match_i,
   input  wire [1:0]  data_addr_match_i,
   input  wire [1:0]  data_match_is_store_i,
   input  wire [1:0]  dbg_counter_expire_i,
   input  wire        ext_event_in_a_i,
   input  wire        ext_event_in_b_i,
   input  wire        irq_taken_event_i,
   input  wire        irq_return_event_i,
   input  wire        crit_irq_taken_event_i,
   input  wire        crit_return_event_i,
   input  wire        dbg_irq_enable_i,
   // debug session control
   input  wire        debug_enter_i,
   input  wire        go_exit_i,
   // outputs
   output reg  [21:0] watch_pulse_vec_o,
   output wire        irq_o
);

   // register state
   reg  [`DWPS_CTRL_W-1:0]  dbg_ctrl_primary_reg;
   reg  [`DWPS_INT_W-1:0]   int_stat_reg;
   reg  [`DWPS_INT_W-1:0]   int_mask_reg;
   reg                      session_reg;
   reg  [3:0]               evout_pulse_reg;
   reg  [21:0]              watch_next;
   reg  [`DWPS_INT_W-1:0]   int_set;

   wire wr_en = psel_i & penable_i & pwrite_i;
   wire rd_en = psel_i & penable_i & ~pwrite_i;
   wire internal_dbg_mode = dbg_ctrl_primary_reg[`DWPS_CTRL_IDM];
   wire external_dbg_mode = dbg_ctrl_primary_reg[`DWPS_CTRL_EDM];
   wire mode_on = internal_dbg_mode | external_dbg_mode;          // [R1]
   wire [1:0] dac1_en = dbg_ctrl_primary_reg[`DWPS_CTRL_DAC1E+1 -:2];
   wire [1:0] dac2_en = dbg_ctrl_primary_reg[`DWPS_CTRL_DAC2E+1 -:2];
   // dbg_irq_enable_i is deliberately not used by any line
   wire unused_de = dbg_irq_enable_i;                            // [R7]

   // zero-wait slave; every unmapped offset gives an error answer
   wire addr_ok = (paddr_i == `DWPS_CTRL_OFF)  ||
                  (paddr_i == `DWPS_EVOUT_OFF) ||
                  (paddr_i == `DWPS_STAT_OFF)  ||
                  (paddr_i == `DWPS_INTST_OFF) ||
                  (paddr_i == `DWPS_INTMSK_OFF)||
                  (paddr_i == `DWPS_WATCH_OFF);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   assign irq_o     = |(int_stat_reg & int_mask_reg);

   // data compare gating: both enables off means any access qualifies
   function dac_hit;
      input       hit;
      input       is_store;
      input [1:0] en;  // bit0 load, bit1 store
      begin
         if (en == 2'b00) begin
            dac_hit = hit;                                       // [R15]
         end else begin
            dac_hit = hit & (is_store ? en[1] : en[0]);          // [R15]
         end
      end
   endfunction

   // line map; status-backed events masked in session and mode off
   always @* begin
      watch_next = 22'h000000;
      watch_next[3:0]   = instr_addr_match_i[3:0];               // [R9]
      watch_next[4]     = dac_hit(data_addr_match_i[0],
                             data_match_is_store_i[0], dac1_en);
      watch_next[5]     = dac_hit(data_addr_match_i[1],
                             data_match_is_store_i[1], dac2_en);
      watch_next[7:6]   = dbg_counter_expire_i;                  // [R10]
      watch_next[9:8]   = instr_addr_match_i[5:4];               // [R11]
      watch_next[15:14] = instr_addr_match_i[7:6];               // [R11]
      watch_next[16]    = irq_taken_event_i;                     // [R14]
      watch_next[17]    = irq_return_event_i;                    // [R14]
      watch_next[18]    = crit_irq_taken_event_i;                // [R14]
      watch_next[19]    = crit_return_event_i;                   // [R14]
      // status-backed lines blocked while a session runs
      if (session_reg | ~mode_on) begin
         watch_next = 22'h000000;                                // [R6] [R1]
      end
      // external inputs pass during a session but need a mode bit
      watch_next[10] = ext_event_in_a_i & mode_on;               // [R12]
      watch_next[11] = ext_event_in_b_i & mode_on;               // [R12]
      // event-output lines: no mode or session qualification
      watch_next[12] = evout_pulse_reg[0];                       // [R13] [R3]
      watch_next[13] = evout_pulse_reg[1];                       // [R13]
      watch_next[20] = evout_pulse_reg[2];                       // [R13]
      watch_next[21] = evout_pulse_reg[3];                       // [R13]
   end

   // interrupt events
   always @* begin
      int_set = {`DWPS_INT_W{1'b0}};
      int_set[`DWPS_INT_WATCH]   = |watch_next;
      int_set[`DWPS_INT_SESS_ST] = debug_enter_i & ~session_reg;
      int_set[`DWPS_INT_SESS_EN] = go_exit_i & session_reg;
   end

   // registered outputs: one cycle after the event, single pulse per event
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         watch_pulse_vec_o <= 22'h000000;                        // [R17]
      end else begin
         watch_pulse_vec_o <= watch_next;                        // [R8] [R2] [R5]
      end
   end

   // event-output write makes a one-cycle pulse, then self-clears
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         evout_pulse_reg <= 4'h0;
      end else if (wr_en && paddr_i == `DWPS_EVOUT_OFF) begin
         evout_pulse_reg <= pwdata_i[3:0];                       // [R13]
      end else begin
         evout_pulse_reg <= 4'h0;                                // [R17]
      end
   end

   // session tracking: entry opens, go-with-exit closes
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         session_reg <= 1'b0;
      end else if (go_exit_i) begin
         session_reg <= 1'b0;                                    // [R16]
      end else if (debug_enter_i) begin
         session_reg <= 1'b1;                                    // [R16]
      end
   end

   // control and mask registers; compare config applies regardless of mode
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dbg_ctrl_primary_reg <= `DWPS_CTRL_RST;
         int_mask_reg         <= {`DWPS_INT_W{1'b0}};
      end else if (wr_en) begin
         if (paddr_i == `DWPS_CTRL_OFF) begin
            dbg_ctrl_primary_reg <= pwdata_i[`DWPS_CTRL_W-1:0];  // [R4]
         end
         if (paddr_i == `DWPS_INTMSK_OFF) begin
            int_mask_reg <= pwdata_i[`DWPS_INT_W-1:0];
         end
      end
   end

   // sticky interrupt status, write one to clear; a new event wins
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         int_stat_reg <= {`DWPS_INT_W{1'b0}};
      end else if (wr_en && paddr_i == `DWPS_INTST_OFF) begin
         int_stat_reg <= (int_stat_reg & ~pwdata_i[`DWPS_INT_W-1:0])
                         | int_set;
      end else begin
         int_stat_reg <= int_stat_reg | int_set;
      end
   end

   // read data, registered at the end of the setup phase
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prdata_o <= 32'h00000000;
      end else if (psel_i & ~penable_i & ~pwrite_i) begin
         case (paddr_i)
            `DWPS_CTRL_OFF:
               prdata_o <= {26'h0000000, dbg_ctrl_primary_reg};
            `DWPS_STAT_OFF:
               prdata_o <= {31'h00000000, session_reg};
            `DWPS_INTST_OFF:
               prdata_o <= {29'h00000000, int_stat_reg};
            `DWPS_INTMSK_OFF:
               prdata_o <= {29'h00000000, int_mask_reg};
            `DWPS_WATCH_OFF:
               prdata_o <= {10'h000, watch_pulse_vec_o};
            default:
               prdata_o <= 32'h00000000;  // event-output reads as zero
         endcase
      end
   end

   wire unused_rd = rd_en;
endmodule

// ==== shared/dwps_regs.vh ====
// constants and register map of the debug watchpoint signalling block
// Operation
// [R1] watchpoints produced while internal or external debug mode bit is set
// [R2] watchpoints reported on a 22-bit output vector, lines 0 to 21
// [R3] event-output field watchpoints ignore both debug mode bits
// [R4] event configuration sets up sources even when primary enable is off
// [R5] line asserts whenever status would record event; no per-line enable
// [R6] debug session blocks status events except external inputs and outputs
// [R7] debug interrupt enable has no effect on watchpoint lines
// [R8] each line asserts in the cycle after its triggering event
// [R9] lines 0-3 instruction compares 1-4, lines 4-5 data compares 1-2
// [R10] lines 6 and 7 flag debug counter one and two reaching zero
// [R11] lines 8-9 instruction compares 5-6, lines 14-15 compares 7-8
// [R12] lines 10 and 11 flag external debug event inputs a and b
// [R13] writing 1 to event-output bits 0-3 asserts lines 12,13,20,21
// [R14] lines 16-19 flag interrupt, return, critical interrupt, critical return
// [R15] data compare fully disabled: loads and stores both trigger its line
// [R16] session starts at first debug entry, ends at go-with-exit release
// [R17] each line is a one-cycle pulse; all lines low during reset
`ifndef DWPS_REGS_VH
`define DWPS_REGS_VH
`define DWPS_NUM_LINES   22
`define DWPS_ADDR_W      8
// register byte offsets
`define DWPS_CTRL_OFF    8'h00
`define DWPS_EVOUT_OFF   8'h04
`define DWPS_STAT_OFF    8'h08
`define DWPS_INTST_OFF   8'h0c
`define DWPS_INTMSK_OFF  8'h10
`define DWPS_WATCH_OFF   8'h14
// control register fields
`define DWPS_CTRL_IDM    0
`define DWPS_CTRL_EDM    1
`define DWPS_CTRL_DAC1E  2
`define DWPS_CTRL_DAC2E  4
`define DWPS_CTRL_W      6
`define DWPS_CTRL_RST    6'h00
// status register fields
`define DWPS_STAT_SESS   0
// interrupt status fields
`define DWPS_INT_WATCH   0
`define DWPS_INT_SESS_ST 1
`define DWPS_INT_SESS_EN 2
`define DWPS_INT_W       3
`endif
